// ### audio_monitor.sv
// Checker of register effects and serial pin timing at the port boundary
`timescale 1ns/1ns
module audio_monitor (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [3:0] video_loss_i,
  input wire logic cascade_irq_i,
  input wire logic playback_bit_clock_oe_o,
  input wire logic playback_frame_sync_oe_o,
  input wire logic record_bit_clock_o,
  input wire logic record_frame_sync_o,
  input wire logic record_serial_data_o,
  input wire logic mix_serial_data_o,
  input wire logic data_oe_o,
  input wire logic [3:0] analog_output_gain_o,
  input wire logic [15:0] analog_input_gain_o,
  input wire logic irq_o
);
  import audio_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  oe_write_a:
    assert property (reg_wr_i && ce_i && reg_addr_i == ADDR_MISC |-> ##2
      data_oe_o == $past(reg_wdata_i[MISC_OE_BIT], 2)) else $error("oe bad");
  pb_dir_a:
    assert property (reg_wr_i && ce_i && reg_addr_i == ADDR_PLAYBACK_CONTROL |-> ##2
      playback_bit_clock_oe_o == $past(reg_wdata_i[6], 2)) else $error("pb dir bad");
  pb_pair_a:
    assert property (playback_frame_sync_oe_o == playback_bit_clock_oe_o) else $error("pair");
  gain_write_a:
    assert property (reg_wr_i && ce_i && reg_addr_i == ADDR_OUTPUT_GAIN_MIX |-> ##2
      analog_output_gain_o == $past(reg_wdata_i[7:4], 2)) else $error("gain bad");
  input_gain_a:
    assert property (reg_wr_i && ce_i && reg_addr_i == ADDR_INPUT_GAIN_A |-> ##2
      analog_input_gain_o[15:8] == $past(reg_wdata_i, 2)) else $error("input gain bad");
  unmapped_zero_a:
    assert property (reg_rd_i && ce_i && reg_addr_i == 8'h50 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read");
  rdata_hold_a:
    assert property (!(reg_rd_i && ce_i) |=> $stable(reg_rdata_o)) else $error("rdata moved");
  loss_irq_a:
    assert property (ce_i && video_loss_i != 4'h0 |-> ##[1:3] irq_o) else $error("no irq");
  cascade_irq_a:
    assert property (ce_i && cascade_irq_i |-> ##[1:4] irq_o) else $error("no cascade irq");
  shared_edge_a:
    assert property ($rose(record_bit_clock_o) |-> $stable(record_serial_data_o)
      && $stable(mix_serial_data_o) && $stable(record_frame_sync_o)) else $error("edge");
  bit_rate_a:
    assert property (data_oe_o && $changed(record_bit_clock_o) |-> ##1
      $stable(record_bit_clock_o)[*8] ##[1:33] $changed(record_bit_clock_o))
      else $error("bit clock rate");
  cover property (data_oe_o && $rose(record_frame_sync_o));
  cover property ($rose(playback_bit_clock_oe_o));
  cover property ($rose(irq_o));
endmodule // audio_monitor
bind audio_serial_port audio_monitor mon (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .video_loss_i(video_loss_i),
  .cascade_irq_i(cascade_irq_i), .playback_bit_clock_oe_o(playback_bit_clock_oe_o),
  .playback_frame_sync_oe_o(playback_frame_sync_oe_o), .data_oe_o(data_oe_o),
  .record_bit_clock_o(record_bit_clock_o), .record_frame_sync_o(record_frame_sync_o),
  .record_serial_data_o(record_serial_data_o), .mix_serial_data_o(mix_serial_data_o),
  .analog_output_gain_o(analog_output_gain_o), .analog_input_gain_o(analog_input_gain_o),
  .irq_o(irq_o));

// ### audio_pkg.sv
// Constants, field layouts and carrier types of the multichannel audio serial port
package audio_pkg;

  // Timing
  localparam int unsigned MCLK_HZ = 20_000_000;
  localparam int unsigned RATE_LOW_HZ = 8000;
  localparam logic [24:0] MCLK_CYCLES = 25'(MCLK_HZ);
  localparam logic [24:0] BASE_INC = 25'(2 * RATE_LOW_HZ);
  localparam int unsigned DET_PERIOD_BASE = 4;

  // Register offsets
  localparam logic [7:0] ADDR_MISC = 8'h43;
  localparam logic [7:0] ADDR_DETECT_STATUS = 8'h5a;
  localparam logic [7:0] ADDR_INPUT_GAIN_A = 8'h60;
  localparam logic [7:0] ADDR_INPUT_GAIN_B = 8'h61;
  localparam logic [7:0] ADDR_RECORD_CONTROL = 8'h62;
  localparam logic [7:0] ADDR_RECORD_SLOT_COUNT = 8'h63;
  localparam logic [7:0] ADDR_SLOT_SEQUENCE_0 = 8'h64;
  localparam logic [7:0] ADDR_SLOT_SEQUENCE_7 = 8'h6b;
  localparam logic [7:0] ADDR_PLAYBACK_CONTROL = 8'h6c;
  localparam logic [7:0] ADDR_MIX_RATIO_A = 8'h6e;
  localparam logic [7:0] ADDR_MIX_RATIO_B = 8'h6f;
  localparam logic [7:0] ADDR_OUTPUT_GAIN_MIX = 8'h70;
  localparam logic [7:0] ADDR_DETECT_CONFIG = 8'h72;
  localparam logic [7:0] ADDR_DETECT_THRESHOLD_A = 8'h73;
  localparam logic [7:0] ADDR_DETECT_THRESHOLD_B = 8'h74;

  // Field positions and reset values
  localparam int unsigned MISC_OE_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [1:0] {STAGE_MIDDLE, STAGE_FIRST, STAGE_LAST, STAGE_SINGLE} stage_t;

  typedef struct packed {
    stage_t stage;
    logic lr_swap;
    logic slot_bits8;
    logic data_mode;
    logic rate16;
    logic width8;
    logic dsp;
  } record_control_t;

  typedef struct packed {
    logic unused;
    logic master;
    logic side_right;
    logic slot_bits8;
    logic data_mode;
    logic rate16;
    logic width8;
    logic dsp;
  } playback_control_t;

  typedef struct packed {
    logic [4:0] unused;
    logic mix_line_record_use;
    logic [1:0] count;
  } slot_count_t;

  typedef struct packed {
    logic method;
    logic [2:0] period;
    logic [3:0] threshold_msb;
  } detect_config_t;

  typedef logic [3:0][15:0] quad_sample_t;

endpackage

// ### audio_serial_port.sv
// Record, mix and playback serial audio ports with registers, mixer and detectors
`timescale 1ns/1ns
module audio_serial_port (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire audio_pkg::quad_sample_t adc_sample_i,
  input wire logic adc_valid_i,
  input wire logic [3:0] video_loss_i,
  input wire logic cascade_irq_i,
  input wire logic playback_bit_clock_i,
  output logic playback_bit_clock_o,
  output logic playback_bit_clock_oe_o,
  input wire logic playback_frame_sync_i,
  output logic playback_frame_sync_o,
  output logic playback_frame_sync_oe_o,
  input wire logic playback_serial_data_i,
  output logic record_bit_clock_o,
  output logic record_frame_sync_o,
  output logic record_serial_data_o,
  output logic mix_serial_data_o,
  output logic data_oe_o,
  output logic [15:0] dac_sample_o,
  output logic [3:0] analog_output_gain_o,
  output logic [15:0] analog_input_gain_o,
  output logic irq_o
);
  import audio_pkg::*;

  typedef struct packed {
    logic [7:0] gain_a;
    logic [7:0] gain_b;
    logic [7:0] rec_ctl;
    logic [7:0] slot_cnt;
    logic [7:0] pb_ctl;
    logic [7:0] ratio_a;
    logic [7:0] ratio_b;
    logic [7:0] gain_mix;
    logic [7:0] det_cfg;
    logic [7:0] th_a;
    logic [7:0] th_b;
    logic [7:0] misc;
    logic [7:0] rdata;
    logic [15:0][3:0] seq;
    logic [24:0] rec_acc;
    logic rec_bclk;
    logic [7:0] rec_pos;
    logic rec_sync;
    logic rec_dat;
    logic mix_dat;
    logic [15:0][15:0] frame;
    logic [15:0] mix_f;
    logic [24:0] pb_acc;
    logic pb_bclk;
    logic [4:0] pb_pos;
    logic pb_sync;
    quad_sample_t own;
    logic [15:0] mix;
    logic [15:0] pb_word;
    logic [15:0] dac;
    logic [15:0][15:0] casc;
    logic [2:0] tog_s;
    logic [1:0] irq_s;
    logic irq;
  } main_t;

  typedef struct packed {
    logic [1:0][2:0] cfg_s;
    logic prev_sync;
    logic [3:0] slot;
    logic [3:0] bitn;
    logic [14:0] sh;
    logic [15:0][15:0] arr;
    logic [15:0][15:0] hold;
    logic tog;
  } link_t;

  main_t st_q, st_d;
  link_t ln_q, ln_d;
  record_control_t rc;
  playback_control_t pc;
  slot_count_t sc;
  detect_config_t dc;
  logic [3:0] audio_det;
  logic [7:0] detect_status;
  logic [3:0][4:0] thresh;

  assign rc = record_control_t'(st_q.rec_ctl);
  assign pc = playback_control_t'(st_q.pb_ctl);
  assign sc = slot_count_t'(st_q.slot_cnt);
  assign dc = detect_config_t'(st_q.det_cfg);
  assign thresh[0] = {dc.threshold_msb[0], st_q.th_a[3:0]};
  assign thresh[1] = {dc.threshold_msb[1], st_q.th_a[7:4]};
  assign thresh[2] = {dc.threshold_msb[2], st_q.th_b[3:0]};
  assign thresh[3] = {dc.threshold_msb[3], st_q.th_b[7:4]};
  assign detect_status = {audio_det, video_loss_i};

  ////////////////////////////////////////////////////////////////////////////
  // Audio detectors, one per input channel
  for (genvar g = 0; g < 4; g++)
  begin : g_det
    level_detector #(
      .W(16),
      .PERIOD_BASE(DET_PERIOD_BASE)
    ) u_det (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .sample_i(adc_sample_i[g]),
      .valid_i(adc_valid_i),
      .method_i(dc.method),
      .period_i(dc.period),
      .threshold_i(thresh[g]),
      .detect_o(audio_det[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file, record and mix transmitters, playback master, mixer
  logic [24:0] rec_sum, rec_inc, pb_sum, pb_inc;
  logic [3:0] rec_log, pb_log;
  logic [7:0] rec_mask, rec_np, rec_q;
  logic [8:0] rec_total;
  logic [3:0] rec_slot, rec_bit, rec_nside, seq_pos, rec_ch, mix_ch;
  logic [4:0] pb_np;
  logic [5:0] pb_total;
  logic [3:0] pb_idx;
  logic [15:0] rec_word, mix_word;
  logic signed [23:0] mix_acc;
  logic [2:0] seq_idx;

  always_comb
  begin
    st_d = st_q;
    // Register access
    seq_idx = 3'(reg_addr_i - ADDR_SLOT_SEQUENCE_0);
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        ADDR_MISC: st_d.misc = reg_wdata_i;
        ADDR_INPUT_GAIN_A: st_d.gain_a = reg_wdata_i;
        ADDR_INPUT_GAIN_B: st_d.gain_b = reg_wdata_i;
        ADDR_RECORD_CONTROL: st_d.rec_ctl = reg_wdata_i;
        ADDR_RECORD_SLOT_COUNT: st_d.slot_cnt = reg_wdata_i;
        ADDR_PLAYBACK_CONTROL: st_d.pb_ctl = reg_wdata_i;
        ADDR_MIX_RATIO_A: st_d.ratio_a = reg_wdata_i;
        ADDR_MIX_RATIO_B: st_d.ratio_b = reg_wdata_i;
        ADDR_OUTPUT_GAIN_MIX: st_d.gain_mix = reg_wdata_i;
        ADDR_DETECT_CONFIG: st_d.det_cfg = reg_wdata_i;
        ADDR_DETECT_THRESHOLD_A: st_d.th_a = reg_wdata_i;
        ADDR_DETECT_THRESHOLD_B: st_d.th_b = reg_wdata_i;
        default:
        begin
          if (reg_addr_i >= ADDR_SLOT_SEQUENCE_0 && reg_addr_i <= ADDR_SLOT_SEQUENCE_7)
          begin
            st_d.seq[{seq_idx, 1'b0}] = reg_wdata_i[3:0];
            st_d.seq[{seq_idx, 1'b1}] = reg_wdata_i[7:4];
          end
        end
      endcase
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_DETECT_STATUS: st_d.rdata = detect_status;
        ADDR_MISC: st_d.rdata = st_q.misc;
        ADDR_INPUT_GAIN_A: st_d.rdata = st_q.gain_a;
        ADDR_INPUT_GAIN_B: st_d.rdata = st_q.gain_b;
        ADDR_RECORD_CONTROL: st_d.rdata = st_q.rec_ctl;
        ADDR_RECORD_SLOT_COUNT: st_d.rdata = st_q.slot_cnt;
        ADDR_PLAYBACK_CONTROL: st_d.rdata = st_q.pb_ctl;
        ADDR_MIX_RATIO_A: st_d.rdata = st_q.ratio_a;
        ADDR_MIX_RATIO_B: st_d.rdata = st_q.ratio_b;
        ADDR_OUTPUT_GAIN_MIX: st_d.rdata = st_q.gain_mix;
        ADDR_DETECT_CONFIG: st_d.rdata = st_q.det_cfg;
        ADDR_DETECT_THRESHOLD_A: st_d.rdata = st_q.th_a;
        ADDR_DETECT_THRESHOLD_B: st_d.rdata = st_q.th_b;
        default:
        begin
          if (reg_addr_i >= ADDR_SLOT_SEQUENCE_0 && reg_addr_i <= ADDR_SLOT_SEQUENCE_7)
            st_d.rdata = {st_q.seq[{seq_idx, 1'b1}], st_q.seq[{seq_idx, 1'b0}]};
          else
            st_d.rdata = 8'h00;
        end
      endcase
    end

    // Record bit clock: fractional divider at rate x bits per frame x 2
    rec_log = (rc.slot_bits8 ? 4'h3 : 4'h4) + 4'h1 + {2'b00, sc.count};
    rec_total = 9'(1) << rec_log;
    rec_mask = 8'(rec_total - 9'h001);
    rec_inc = BASE_INC << ({3'b000, rc.rate16} + rec_log);
    rec_sum = st_q.rec_acc + rec_inc;
    rec_np = (st_q.rec_pos + 8'h01) & rec_mask;
    rec_q = (rec_np - 8'h01) & rec_mask;
    rec_slot = rc.slot_bits8 ? 4'(rec_q >> 3) : 4'(rec_q >> 4);
    rec_bit = rc.slot_bits8 ? {1'b0, rec_q[2:0]} : rec_q[3:0];
    rec_nside = 4'(1) << sc.count;
    if (!rc.dsp && rec_slot >= rec_nside)
      seq_pos = 4'h8 + (rec_slot - rec_nside);
    else
      seq_pos = rec_slot;
    rec_ch = st_q.seq[seq_pos];
    mix_ch = st_q.seq[4'hf - seq_pos];
    rec_word = st_q.frame[rec_ch];
    mix_word = sc.mix_line_record_use ? st_q.frame[mix_ch] : st_q.mix_f;
    if (rec_sum >= MCLK_CYCLES)
    begin
      st_d.rec_acc = rec_sum - MCLK_CYCLES;
      st_d.rec_bclk = ~st_q.rec_bclk;
      if (st_q.rec_bclk)
      begin
        // Falling edge: advance and drive the next bit
        st_d.rec_pos = rec_np;
        st_d.rec_sync = rc.dsp ? (rec_np == 8'h00) : ({1'b0, rec_np} >= (rec_total >> 1));
        st_d.rec_dat = (rec_bit < (rc.width8 ? 4'h8 : 4'hf) || (!rc.width8)) ?
          rec_word[4'hf - rec_bit] : 1'b0;
        st_d.mix_dat = (rec_bit < (rc.width8 ? 4'h8 : 4'hf) || (!rc.width8)) ?
          mix_word[4'hf - rec_bit] : 1'b0;
        if (rec_np == 8'h00)
        begin
          for (int i = 0; i < 16; i++)
            if (i < 4)
              st_d.frame[i] = st_q.own[i];
            else
              st_d.frame[i] = (rc.stage == STAGE_SINGLE) ? 16'h0000 : st_q.casc[i];
          st_d.mix_f = st_q.mix;
        end
      end
    end
    else
      st_d.rec_acc = rec_sum;

    // Playback master clock and sync, stereo frame
    pb_log = (pc.slot_bits8 ? 4'h3 : 4'h4) + 4'h1;
    pb_total = 6'(1) << pb_log;
    pb_inc = BASE_INC << ({3'b000, pc.rate16} + pb_log);
    pb_sum = st_q.pb_acc + pb_inc;
    pb_np = (st_q.pb_pos + 5'h01) & 5'(pb_total - 6'h01);
    if (!pc.master)
    begin
      st_d.pb_acc = 25'h0000000;
      st_d.pb_bclk = 1'b0;
      st_d.pb_pos = 5'h00;
      st_d.pb_sync = 1'b0;
    end
    else if (pb_sum >= MCLK_CYCLES)
    begin
      st_d.pb_acc = pb_sum - MCLK_CYCLES;
      st_d.pb_bclk = ~st_q.pb_bclk;
      if (st_q.pb_bclk)
      begin
        st_d.pb_pos = pb_np;
        st_d.pb_sync = pc.dsp ? (pb_np == 5'h00) : ({1'b0, pb_np} >= (pb_total >> 1));
      end
    end
    else
      st_d.pb_acc = pb_sum;

    // Frame words from the link domain, toggle handshake
    st_d.tog_s = {st_q.tog_s[1], st_q.tog_s[0], ln_q.tog};
    pb_idx = pc.dsp ? {3'b000, pc.side_right} : {pc.side_right, 3'b000};
    if (st_q.tog_s[1] != st_q.tog_s[2])
    begin
      st_d.casc = ln_q.hold;
      st_d.pb_word = ln_q.hold[pb_idx] & (pc.width8 ? 16'hff00 : 16'hffff);
    end

    // Mixer on each new input sample
    mix_acc = 24'sd0;
    if (adc_valid_i)
    begin
      st_d.own = adc_sample_i;
      mix_acc = 24'(signed'(adc_sample_i[0]) * signed'({1'b0, st_q.ratio_a[3:0]}))
        + 24'(signed'(adc_sample_i[1]) * signed'({1'b0, st_q.ratio_a[7:4]}))
        + 24'(signed'(adc_sample_i[2]) * signed'({1'b0, st_q.ratio_b[3:0]}))
        + 24'(signed'(adc_sample_i[3]) * signed'({1'b0, st_q.ratio_b[7:4]}))
        + 24'(signed'(st_q.pb_word) * signed'({1'b0, st_q.gain_mix[3:0]}));
      mix_acc = mix_acc >>> 4;
      if (mix_acc > 24'sd32767)
        st_d.mix = 16'h7fff;
      else if (mix_acc < -24'sd32768)
        st_d.mix = 16'h8000;
      else
        st_d.mix = mix_acc[15:0];
      st_d.dac = (rc.stage == STAGE_LAST) ? st_q.pb_word : st_d.mix;
    end

    // Interrupt from detection, video loss and downstream chips
    st_d.irq_s = {st_q.irq_s[0], cascade_irq_i};
    st_d.irq = (|detect_status) | st_q.irq_s[1];
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_q <= '0;
      for (int k = 0; k < 16; k++)
        st_q.seq[k] <= 4'(k);
    end
    else if (ce_i)
      st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Playback receiver on the playback bit clock
  logic ln_dsp, ln_slot8, ln_width8, ln_start, ln_frame, ln_last;
  logic [15:0] ln_word;

  always_comb
  begin
    ln_d = ln_q;
    ln_d.cfg_s = {ln_q.cfg_s[0], {pc.dsp, pc.slot_bits8, pc.width8}};
    {ln_dsp, ln_slot8, ln_width8} = ln_q.cfg_s[1];
    ln_start = ln_dsp ? (playback_frame_sync_i & ~ln_q.prev_sync)
                      : (playback_frame_sync_i != ln_q.prev_sync);
    ln_frame = ln_start & (ln_dsp | ~playback_frame_sync_i);
    ln_last = ln_q.bitn == (ln_slot8 ? 4'h7 : 4'hf);
    ln_word = ln_slot8 ? {ln_q.sh[6:0], playback_serial_data_i, 8'h00}
                       : {ln_q.sh, playback_serial_data_i};
    ln_d.prev_sync = playback_frame_sync_i;
    ln_d.sh = {ln_q.sh[13:0], playback_serial_data_i};
    if (ln_last)
    begin
      ln_d.arr[ln_q.slot] = ln_word & (ln_width8 ? 16'hff00 : 16'hffff);
      ln_d.slot = ln_q.slot + 4'h1;
      ln_d.bitn = 4'h0;
    end
    else
      ln_d.bitn = ln_q.bitn + 4'h1;
    if (ln_start)
    begin
      ln_d.slot = (!ln_dsp && playback_frame_sync_i) ? 4'h8 : 4'h0;
      ln_d.bitn = 4'h0;
    end
    if (ln_frame)
    begin
      ln_d.hold = ln_d.arr;
      ln_d.tog = ~ln_q.tog;
    end
  end

  always_ff @(posedge playback_bit_clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ln_q <= '0;
    else
      ln_q <= ln_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_o = st_q.rdata;
  assign playback_bit_clock_o = st_q.pb_bclk;
  assign playback_frame_sync_o = st_q.pb_sync;
  assign playback_bit_clock_oe_o = pc.master;
  assign playback_frame_sync_oe_o = pc.master;
  assign record_bit_clock_o = st_q.rec_bclk;
  assign record_frame_sync_o = st_q.rec_sync;
  assign record_serial_data_o = st_q.rec_dat;
  assign mix_serial_data_o = st_q.mix_dat;
  assign data_oe_o = st_q.misc[MISC_OE_BIT];
  assign dac_sample_o = st_q.dac;
  assign analog_output_gain_o = st_q.gain_mix[7:4];
  assign analog_input_gain_o = {st_q.gain_a, st_q.gain_b};
  assign irq_o = st_q.irq;
endmodule // audio_serial_port

// ### level_detector.sv
// Per-channel audio presence detector
`timescale 1ns/1ns
module level_detector #(
  parameter int unsigned W = 16,
  parameter int unsigned PERIOD_BASE = 4
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [W-1:0] sample_i,
  input wire logic valid_i,
  input wire logic method_i,
  input wire logic [2:0] period_i,
  input wire logic [4:0] threshold_i,
  output logic detect_o
);
  localparam int unsigned CW = PERIOD_BASE + 7;
  localparam int unsigned AW = W + CW;

  typedef struct packed {
    logic [W-1:0] prev;
    logic [AW-1:0] acc;
    logic [CW-1:0] cnt;
    logic det;
  } det_state_t;

  det_state_t st_q, st_d;
  logic [W:0] diff;
  logic [W:0] absd;
  logic [W-1:0] mag;
  logic [AW-1:0] sum;
  logic [AW-1:0] avg;
  logic [CW-1:0] last;

  always_comb
  begin
    st_d = st_q;
    diff = {sample_i[W-1], sample_i} - {st_q.prev[W-1], st_q.prev};
    absd = diff[W] ? (W+1)'(-diff) : diff;
    if (method_i)
      mag = absd[W] ? {W{1'b1}} : absd[W-1:0];
    else
      mag = sample_i[W-1] ? W'(-sample_i) : sample_i;
    last = CW'((1 << (period_i + PERIOD_BASE)) - 1);
    sum = st_q.acc + AW'(mag);
    avg = sum >> (period_i + PERIOD_BASE);
    if (valid_i)
    begin
      st_d.prev = sample_i;
      if (st_q.cnt == last)
      begin
        st_d.det = avg[W-1:W-5] > threshold_i;
        st_d.acc = '0;
        st_d.cnt = '0;
      end
      else
      begin
        st_d.acc = sum;
        st_d.cnt = st_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st_q <= '0;
    else if (ce_i)
      st_q <= st_d;
  end

  assign detect_o = st_q.det;
endmodule // level_detector

// ### playback_source.sv
// Playback source model: one stereo frame per request on its own bit clock
`timescale 1ns/1ns
module playback_source (
  input wire logic go_i,
  input wire logic [15:0] left_i,
  input wire logic [15:0] right_i,
  output logic clk_o,
  output logic sync_o,
  output logic data_o
);
  logic [31:0] word;
  logic first;
  task automatic send_bit(input logic s, input logic d);
    sync_o = s;
    data_o = d;
    #15 clk_o = 1'b1;
    #15 clk_o = 1'b0;
  endtask
  initial
  begin
    clk_o = 1'b0;
    sync_o = 1'b1;
    data_o = 1'b0;
    first = 1'b1;
    forever
    begin
      @(posedge go_i);
      word = {left_i, right_i};
      #7;
      // Sync fall once so the receiver starts on a left half
      if (first)
      begin
        send_bit(1'b1, 1'b0);
        send_bit(1'b0, 1'b0);
        first = 1'b0;
      end
      for (int i = 1; i <= 32; i++)
        send_bit(i >= 16 && i < 32, word[32-i]);
      // Clock stops; released data shows the inverse of its last bit
      data_o = ~data_o;
    end
  end
endmodule // playback_source

// ### tb.sv
// Self-checking bench of the serial audio port
`timescale 1ns/1ns
module tb;
  import audio_pkg::*;
  logic mclk_i, rstn_i, ce_i, reg_wr_i, reg_rd_i, adc_valid_i, cascade_irq_i, go, rd_taken;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, g;
  quad_sample_t adc_sample_i;
  logic [3:0] video_loss_i;
  logic pb_clk, pb_clk_oe, pb_sync, pb_sync_oe, src_clk, src_sync, src_data, data_oe_o;
  logic [15:0] dac_sample_o, dac_last, left, right, expw, prev_exp;
  logic [7:0] exp_q[$];
  logic [15:0] dac_q[$];
  logic rec_bclk, rec_sync, rec_dat, rec_prev;
  logic [15:0] rec_sh;
  logic [15:0] rec_q[$];
  logic [7:0] rw_list[8] = '{8'h60, 8'h61, 8'h65, 8'h6a, 8'h6e, 8'h6f, 8'h70, 8'h73};
  int bad_count, checks;
  audio_serial_port dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .adc_sample_i(adc_sample_i),
    .adc_valid_i(adc_valid_i), .video_loss_i(video_loss_i), .cascade_irq_i(cascade_irq_i),
    .playback_bit_clock_i(pb_clk_oe ? pb_clk : src_clk), .playback_bit_clock_o(pb_clk),
    .playback_bit_clock_oe_o(pb_clk_oe), .playback_frame_sync_i(pb_sync_oe ? pb_sync : src_sync),
    .playback_frame_sync_o(pb_sync), .playback_frame_sync_oe_o(pb_sync_oe),
    .playback_serial_data_i(src_data), .record_bit_clock_o(rec_bclk),
    .record_frame_sync_o(rec_sync), .record_serial_data_o(rec_dat),
    .mix_serial_data_o(), .data_oe_o(data_oe_o),
    .dac_sample_o(dac_sample_o), .analog_output_gain_o(), .analog_input_gain_o(), .irq_o());
  playback_source src (.go_i(go), .left_i(left), .right_i(right), .clk_o(src_clk),
    .sync_o(src_sync), .data_o(src_data));
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_dac(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: dac got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rec(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: record got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    exp_q.push_back(e);
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i) rd_taken <= reg_rd_i && ce_i;
  always @(negedge mclk_i)
  begin
    if (rd_taken)
      cmp_reg(reg_rdata_o, exp_q.pop_front());
    if (dac_sample_o !== dac_last)
    begin
      cmp_dac(dac_sample_o, dac_q.size() ? dac_q.pop_front() : ~dac_sample_o);
      dac_last = dac_sample_o;
    end
  end
  // Record line: a right word is complete when sync falls
  always @(posedge rec_bclk)
  begin
    rec_sh = {rec_sh[14:0], rec_dat};
    if (rec_prev && !rec_sync && rec_q.size() != 0)
      cmp_rec(rec_sh, rec_q.pop_front());
    rec_prev = rec_sync;
  end
  // Small samples keep every detector quiet
  always @(negedge mclk_i)
  begin
    adc_valid_i <= 1'($urandom);
    for (int k = 0; k < 4; k++)
      adc_sample_i[k] <= 16'($signed(11'($urandom)));
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rstn_i, reg_wr_i, reg_rd_i, cascade_irq_i, go, video_loss_i} = '0;
    {reg_addr_i, reg_wdata_i, left, right, dac_last, prev_exp} = '0;
    {bad_count, checks} = '0;
    ce_i = 1'b1;
    void'($urandom(32'h33ef));
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    rstn_i = 1'b1;
    cmp_reg({7'h0, data_oe_o}, 8'h00);
    rd(ADDR_SLOT_SEQUENCE_0, 8'h10);
    rd(ADDR_SLOT_SEQUENCE_7, 8'hfe);
    rd(ADDR_RECORD_CONTROL, REG_RESET);
    // Last stage from here on: the DAC follows playback words only
    wr(ADDR_RECORD_CONTROL, 8'h80);
    foreach (rw_list[i])
    begin
      g = 8'($urandom);
      wr(rw_list[i], g);
      rd(rw_list[i], g);
    end
    wr(ADDR_MIX_RATIO_A, g);
    ce_i = 1'b0;
    wr(ADDR_MIX_RATIO_A, 8'h3c);
    ce_i = 1'b1;
    rd(ADDR_MIX_RATIO_A, g);
    video_loss_i = 4'(($urandom % 15) + 1);
    wr(ADDR_DETECT_STATUS, 8'hff);
    rd(ADDR_DETECT_STATUS, {4'h0, video_loss_i});
    video_loss_i = 4'h0;
    wr(8'h50, 8'h5a);
    rd(8'h50, 8'h00);
    cascade_irq_i = 1'b1;
    @(negedge mclk_i);
    cascade_irq_i = 1'b0;
    wr(ADDR_MISC, 8'h80);
    repeat (2) @(negedge mclk_i);
    cmp_reg({7'h0, data_oe_o}, 8'h01);
    for (int s = 0; s < 2; s++)
    begin
      wr(ADDR_PLAYBACK_CONTROL, 8'(s << 5));
      repeat (3)
      begin
        left = 16'($urandom);
        right = 16'($urandom);
        expw = s ? right : left;
        if (expw !== prev_exp)
          dac_q.push_back(expw);
        prev_exp = expw;
        go = 1'b1;
        @(negedge mclk_i);
        go = 1'b0;
        repeat (30) @(negedge mclk_i);
      end
    end
    cmp_dac(16'(dac_q.size()), 16'h0000);
    // Slot position 8 (right, channel code 8) carries the cascaded right word
    @(negedge rec_sync);
    repeat (60) @(negedge mclk_i);
    rec_q.push_back(right);
    @(negedge rec_sync);
    repeat (60) @(negedge mclk_i);
    cmp_rec(16'(rec_q.size()), 16'h0000);
    wr(ADDR_PLAYBACK_CONTROL, 8'h40);
    rd(ADDR_PLAYBACK_CONTROL, 8'h40);
    repeat (200) @(negedge mclk_i);
    print_verdict();
  end
  // Whole run needs well under 8,000 clock cycles
  initial
  begin
    #400_000;
    bad_count++;
    print_verdict();
  end
endmodule // tb
